// File: design/long_timer_pkg.sv
package long_timer_pkg;

    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [31:0] IDX_PERIOD_LOW  = 32'h0b0000d8;
    localparam logic [31:0] IDX_PERIOD_HIGH = 32'h0b0000da;
    localparam logic [31:0] IDX_COUNT_LOW   = 32'h0b0000dc;
    localparam logic [31:0] IDX_COUNT_HIGH  = 32'h0b0000de;
    localparam logic [31:0] IDX_CYCLE_LOW   = 32'h0b0001c0;
    localparam logic [31:0] IDX_CYCLE_HIGH  = 32'h0b0001c2;
    localparam logic [31:0] IDX_IRQ_STATUS  = 32'h0b0001de;

    // ****************************************************************
    // Field layout and values
    // ****************************************************************
    localparam int          PERIOD_W     = 24;
    localparam int          CYCLE_HIGH_W = 9;
    localparam int          IRQ_BIT      = 2;
    localparam logic [23:0] COUNT_ONE    = 24'h000001;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // ****************************************************************
    // Timing: software gap between period reprogrammings
    // ****************************************************************
    localparam int CLK_PERIOD_NS     = 50;
    localparam int REPROG_GAP_US     = 100;
    localparam int REPROG_GAP_CYCLES = (REPROG_GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_PL   = 3'b001,
        SEL_PH   = 3'b010,
        SEL_CL   = 3'b011,
        SEL_CH   = 3'b100,
        SEL_YL   = 3'b101,
        SEL_YH   = 3'b110,
        SEL_IRQ  = 3'b111
    } reg_sel_t;

    typedef struct packed {
        logic [31:0] awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [31:0] araddr;
        logic        arvalid;
        logic        rready;
    } axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axi_rsp_t;

    typedef struct packed {
        logic [23:0] period;
        logic [23:0] count;
        logic [15:0] stage_low;
        logic [7:0]  stage_high;
        logic        got_low;
        logic        got_high;
        logic [15:0] cycle_low;
        logic [8:0]  cycle_high;
        logic        irq_flag;
        logic [2:0]  sync;
        logic        aw_held;
        logic [29:0] awidx;
        logic        w_held;
        logic [15:0] wdata;
        logic [1:0]  wstrb;
        axi_rsp_t    rsp;
    } state_t;

    localparam state_t STATE_RESET = '0;

endpackage : long_timer_pkg

// File: design/long_period_countdown_timer.sv
`timescale 1ns/1ps
// Notes on behaviour
// [R01] 24-bit period split low and high halves
// [R02] Counter starts from period and counts down
// [R03] New period only after both halves written
// [R04] Software waits 100 us before reprogramming
// [R05] All-zero period stops counting and interrupts
// [R06] Software avoids period values one through four
// [R07] Counter decrements once per slow tick
// [R08] Interrupt raised on the tick that finds the counter at one
// [R09] At one, reload period and keep counting
// [R10] Live count readable as low/high registers
// [R11] Count read directly, no snapshot latch
// [R12] Software reads count twice, compares
// [R13] Unused upper bits read as zero
// [R14] Clock-unit reset clears; others keep timer
// [R15] Second cycle low register, every reset clears
// [R16] Interrupt flag bit two, write one clears
// [R17] Second cycle value 25 bits, high part
// [R18] Staged halves transfer once both written
module long_period_countdown_timer (
    // Clock, reset and enable
    input  wire logic                    clk,
    input  wire logic                    arst_n,
    input  wire logic                    ce,
    // Other resets of the unit, same clock domain
    input  wire logic                    warm_reset,
    // Slow tick clock from the 32.768 kHz domain
    input  wire logic                    rtc_clk_in,
    // Register bus
    input  wire long_timer_pkg::axi_req_t req,
    output long_timer_pkg::axi_rsp_t      rsp,
    // Status
    output logic                         long_timer_irq_flag
);
    import long_timer_pkg::*;

    // ****************************************************************
    // State and next state
    // ****************************************************************
    state_t s;
    state_t n;

    logic        tick;
    logic        load_now;
    logic        set_ev;
    logic        clr_ev;
    logic        wr_go;
    logic [23:0] stage;
    reg_sel_t    wsel;
    reg_sel_t    rsel;
    logic [15:0] rval;
    logic [15:0] yh_merged;

    function automatic reg_sel_t decode(input logic [29:0] idx);
        reg_sel_t r;
        if (idx == IDX_PERIOD_LOW[29:0]) begin
            r = SEL_PL;
        end else if (idx == IDX_PERIOD_HIGH[29:0]) begin
            r = SEL_PH;
        end else if (idx == IDX_COUNT_LOW[29:0]) begin
            r = SEL_CL;
        end else if (idx == IDX_COUNT_HIGH[29:0]) begin
            r = SEL_CH;
        end else if (idx == IDX_CYCLE_LOW[29:0]) begin
            r = SEL_YL;
        end else if (idx == IDX_CYCLE_HIGH[29:0]) begin
            r = SEL_YH;
        end else if (idx == IDX_IRQ_STATUS[29:0]) begin
            r = SEL_IRQ;
        end else begin
            r = SEL_NONE;
        end
        return r;
    endfunction : decode

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d, input logic [1:0] st);
        logic [15:0] r;
        r = old;
        if (st[0]) begin
            r[7:0] = d[7:0];
        end
        if (st[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction : merge

    // ****************************************************************
    // Derived signals
    // ****************************************************************
    // The second and third synchroniser stages feed the edge detector
    assign tick     = s.sync[1] & ~s.sync[2];
    assign stage    = {s.stage_high, s.stage_low};          // [R01]
    assign load_now = s.got_low & s.got_high;               // [R03] [R18]
    assign wr_go    = s.aw_held & s.w_held & ~s.rsp.bvalid;
    assign wsel     = decode(s.awidx);
    assign rsel     = decode(req.araddr[31:2]);
    assign set_ev   = ~load_now & (s.period != '0) & tick & (s.count == COUNT_ONE); // [R08]
    assign clr_ev   = wr_go & (wsel == SEL_IRQ) & s.wstrb[0] & s.wdata[IRQ_BIT]; // [R16]
    assign yh_merged = merge({7'h00, s.cycle_high}, s.wdata, s.wstrb);      // [R17]

    // Count is returned as it stands; a read across a decrement may tear
    always_comb begin
        rval = 16'h0000;
        case (rsel)
            SEL_PL:  rval = s.stage_low;
            SEL_PH:  rval = {8'h00, s.stage_high};          // [R13]
            SEL_CL:  rval = s.count[15:0];                  // [R10] [R11]
            SEL_CH:  rval = {8'h00, s.count[23:16]};        // [R10] [R13]
            SEL_YL:  rval = s.cycle_low;                    // [R15]
            SEL_YH:  rval = {7'h00, s.cycle_high};          // [R17]
            SEL_IRQ: rval = {13'h0000, s.irq_flag, 2'h0};   // [R16]
            default: rval = 16'h0000;
        endcase
    end

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        n      = s;
        n.sync = {s.sync[1:0], rtc_clk_in};

        // Countdown
        if (load_now) begin
            n.period   = stage;                             // [R18]
            n.count    = stage;                             // [R02]
            n.got_low  = 1'b0;
            n.got_high = 1'b0;
        end else if (s.period == '0) begin
            n.count = '0;                                   // [R05]
        end else if (tick) begin
            if (s.count == COUNT_ONE) begin
                n.count = s.period;                         // [R09]
            end else begin
                n.count = s.count - COUNT_ONE;              // [R07]
            end
        end

        // Set wins over a clear in the same cycle
        n.irq_flag = set_ev | (s.irq_flag & ~clr_ev);       // [R16]

        // Write address and data, taken in either order
        if (s.rsp.bvalid && req.bready) begin
            n.rsp.bvalid = 1'b0;
        end
        if (s.rsp.awready && req.awvalid) begin
            n.aw_held = 1'b1;
            n.awidx   = req.awaddr[31:2];
        end
        if (s.rsp.wready && req.wvalid) begin
            n.w_held = 1'b1;
            n.wdata  = req.wdata[15:0];
            n.wstrb  = req.wstrb[1:0];
        end
        if (wr_go) begin
            n.aw_held    = 1'b0;
            n.w_held     = 1'b0;
            n.rsp.bvalid = 1'b1;
            n.rsp.bresp  = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            if (s.wstrb != 2'h0) begin
                case (wsel)
                    SEL_PL: begin
                        n.stage_low = merge(s.stage_low, s.wdata, s.wstrb); // [R01]
                        n.got_low   = 1'b1;                 // [R03]
                    end
                    SEL_PH: begin
                        if (s.wstrb[0]) begin
                            n.stage_high = s.wdata[7:0];    // [R01] [R13]
                        end
                        n.got_high = 1'b1;                  // [R03]
                    end
                    SEL_YL: begin
                        n.cycle_low = merge(s.cycle_low, s.wdata, s.wstrb); // [R15]
                    end
                    SEL_YH: begin
                        n.cycle_high = yh_merged[8:0];      // [R17]
                    end
                    default: begin
                        n.cycle_low = n.cycle_low;
                    end
                endcase
            end
        end

        // Read channel
        if (s.rsp.rvalid && req.rready) begin
            n.rsp.rvalid = 1'b0;
        end
        if (s.rsp.arready && req.arvalid) begin
            n.rsp.rvalid = 1'b1;
            n.rsp.rdata  = {16'h0000, rval};                // [R13]
            n.rsp.rresp  = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end

        // Period and count survive; the second timer does not
        if (warm_reset) begin
            n.cycle_low  = '0;                              // [R14] [R15]
            n.cycle_high = '0;                              // [R17]
        end

        n.rsp.awready = ~n.aw_held & ~n.rsp.bvalid;
        n.rsp.wready  = ~n.w_held & ~n.rsp.bvalid;
        n.rsp.arready = ~n.rsp.rvalid;
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // The asynchronous reset is the clock-unit reset and clears it all
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= STATE_RESET;                               // [R14]
        end else if (ce) begin
            s <= n;
        end
    end

    assign rsp                 = s.rsp;
    assign long_timer_irq_flag = s.irq_flag;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_tick_at_one;
        ce && tick && !load_now && (s.period != '0) && (s.count == COUNT_ONE);
    endsequence

    sequence s_tick_mid;
        ce && tick && !load_now && (s.period != '0) && (s.count > COUNT_ONE);
    endsequence

    property p_half_ignored;
        ce && !load_now |=> s.period == $past(s.period);
    endproperty
    a_half_ignored: assert property (p_half_ignored) else $error("period changed without both halves"); // [R03]

    property p_transfer;
        ce && load_now |=> (s.period == $past(stage)) && (s.count == $past(stage)) && !s.got_high;
    endproperty
    a_transfer: assert property (p_transfer) else $error("staged period not transferred"); // [R18]

    property p_stopped;
        ce && !load_now && (s.period == '0) |=> (s.count == '0) && !$rose(s.irq_flag);
    endproperty
    a_stopped: assert property (p_stopped) else $error("timer ran with zero period"); // [R05]

    property p_decrement;
        s_tick_mid |=> s.count == $past(s.count) - COUNT_ONE;
    endproperty
    a_decrement: assert property (p_decrement) else $error("count did not decrement by one"); // [R07]

    property p_reload;
        s_tick_at_one |=> (s.count == $past(s.period)) && s.irq_flag;
    endproperty
    a_reload: assert property (p_reload) else $error("no reload or flag at one"); // [R09]

    property p_count_still;
        ce && !tick && !load_now |=> s.count == $past(s.count);
    endproperty
    a_count_still: assert property (p_count_still) else $error("count moved without a tick"); // [R07]

    property p_high_zero;
        ce && s.rsp.arready && req.arvalid && (rsel == SEL_PH || rsel == SEL_CH) |=> s.rsp.rdata[31:8] == '0;
    endproperty
    a_high_zero: assert property (p_high_zero) else $error("reserved bits read nonzero"); // [R13]

    property p_count_read;
        ce && s.rsp.arready && req.arvalid && (rsel == SEL_CL) |=> s.rsp.rdata[15:0] == $past(s.count[15:0]);
    endproperty
    a_count_read: assert property (p_count_read) else $error("count low read wrong"); // [R10]

    property p_warm;
        ce && warm_reset |=> (s.cycle_low == '0) && (s.period == $past(s.period) || $past(load_now));
    endproperty
    a_warm: assert property (p_warm) else $error("warm reset effect wrong"); // [R15]

    property p_flag_clear;
        ce && clr_ev && !set_ev |=> !s.irq_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("write-one clear did not clear the flag"); // [R16]

    property p_set_wins;
        s_tick_at_one and (ce && clr_ev) |=> s.irq_flag;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat a same-cycle set"); // [R16]

    property p_flag_set;
        ce && set_ev |=> s.irq_flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not raised at one"); // [R08]

    property p_flag_hold;
        ce && !set_ev && !clr_ev |=> s.irq_flag == $past(s.irq_flag);
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag moved without set or clear"); // [R16]

    property p_irq_read;
        ce && s.rsp.arready && req.arvalid && (rsel == SEL_IRQ) |=> s.rsp.rdata == {29'h0, $past(s.irq_flag), 2'h0};
    endproperty
    a_irq_read: assert property (p_irq_read) else $error("status read wrong"); // [R16]

    property p_got_low;
        ce && wr_go && (wsel == SEL_PL) && (s.wstrb != 2'h0) |=> s.got_low;
    endproperty
    a_got_low: assert property (p_got_low) else $error("low half write not staged"); // [R03]

    property p_got_high;
        ce && wr_go && (wsel == SEL_PH) && (s.wstrb != 2'h0) |=> s.got_high;
    endproperty
    a_got_high: assert property (p_got_high) else $error("high half write not staged"); // [R03]

    property p_stage_high;
        ce && wr_go && (wsel == SEL_PH) && s.wstrb[0] |=> s.stage_high == $past(s.wdata[7:0]);
    endproperty
    a_stage_high: assert property (p_stage_high) else $error("high half staged wrong"); // [R01]

    property p_period_read;
        ce && s.rsp.arready && req.arvalid && (rsel == SEL_PL) |=> s.rsp.rdata[15:0] == $past(s.stage_low);
    endproperty
    a_period_read: assert property (p_period_read) else $error("period low read wrong"); // [R01]

    property p_count_high_read;
        ce && s.rsp.arready && req.arvalid && (rsel == SEL_CH) |=> s.rsp.rdata[7:0] == $past(s.count[23:16]);
    endproperty
    a_count_high_read: assert property (p_count_high_read) else $error("count high read wrong"); // [R10]

    property p_cycle_low_read;
        ce && s.rsp.arready && req.arvalid && (rsel == SEL_YL) |=> s.rsp.rdata[15:0] == $past(s.cycle_low);
    endproperty
    a_cycle_low_read: assert property (p_cycle_low_read) else $error("cycle low read wrong"); // [R15]

    property p_cycle_high_read;
        ce && s.rsp.arready && req.arvalid && (rsel == SEL_YH) |=> s.rsp.rdata[31:9] == '0;
    endproperty
    a_cycle_high_read: assert property (p_cycle_high_read) else $error("cycle high spare bits nonzero"); // [R17]

    property p_warm_high;
        ce && warm_reset |=> s.cycle_high == '0;
    endproperty
    a_warm_high: assert property (p_warm_high) else $error("warm reset kept cycle high"); // [R17]

endmodule : long_period_countdown_timer

// File: tb/long_period_countdown_timer_bench.sv
`timescale 1ns/1ps
module long_period_countdown_timer_bench;
    import long_timer_pkg::*;

    // ****************************************************************
    // Signals and expectation queues
    // ****************************************************************
    logic        clk;
    logic        arst_n;
    logic        ce;
    logic        warm_reset;
    logic        rtc_clk_in;
    axi_req_t    req;
    axi_rsp_t    rsp;
    logic        long_timer_irq_flag;
    logic [15:0] exp_rd[$];
    logic [1:0]  exp_rr[$];
    logic [1:0]  exp_b[$];
    int          num_errors;
    int          checks;
    integer      seed;
    logic [23:0] cur;
    logic [23:0] p;
    logic [31:0] zero_regs[7];
    int          k;

    long_period_countdown_timer dut (
        .clk                 (clk),
        .arst_n              (arst_n),
        .ce                  (ce),
        .warm_reset          (warm_reset),
        .rtc_clk_in          (rtc_clk_in),
        .req                 (req),
        .rsp                 (rsp),
        .long_timer_irq_flag (long_timer_irq_flag)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ****************************************************************
    // Bus tasks
    // ****************************************************************
    task automatic wrap_up();
        if (num_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    task automatic ran_out();
        num_errors++;
        $display("mismatch %0t wait ran out", $time);
        wrap_up();
    endtask : ran_out

    task automatic wr(input logic [31:0] idx, input logic [15:0] data, input logic [1:0] strb,
                      input logic [1:0] resp);
        int   n;
        logic aw_done;
        logic w_done;
        @(posedge clk);
        aw_done = 1'b0;
        w_done  = 1'b0;
        exp_b.push_back(resp);
        req.awaddr  <= {idx[29:0], 2'b00};
        req.awvalid <= 1'b1;
        req.wdata   <= {16'h0000, data};
        req.wstrb   <= {2'b00, strb};
        req.wvalid  <= 1'b1;
        req.bready  <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge clk);
            if (rsp.awready === 1'b1 && !aw_done) begin
                aw_done = 1'b1;
                req.awvalid <= 1'b0;
            end
            if (rsp.wready === 1'b1 && !w_done) begin
                w_done = 1'b1;
                req.wvalid <= 1'b0;
            end
            if (rsp.bvalid === 1'b1) break;
        end
        req.bready <= 1'b0;
        if (n == 200) ran_out();
    endtask : wr

    task automatic rd(input logic [31:0] idx, input logic [15:0] exp, input logic [1:0] resp);
        int n;
        @(posedge clk);
        exp_rd.push_back(exp);
        exp_rr.push_back(resp);
        req.araddr  <= {idx[29:0], 2'b00};
        req.arvalid <= 1'b1;
        req.rready  <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge clk);
            if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
            if (rsp.rvalid === 1'b1) break;
        end
        req.rready <= 1'b0;
        if (n == 200) ran_out();
    endtask : rd

    task automatic cnt(input logic [23:0] v);
        rd(IDX_COUNT_LOW, v[15:0], RESP_OKAY);
        rd(IDX_COUNT_HIGH, {8'h00, v[23:16]}, RESP_OKAY);
    endtask : cnt

    task automatic set_period(input logic [23:0] v);
        wr(IDX_PERIOD_LOW, v[15:0], 2'b11, RESP_OKAY);
        wr(IDX_PERIOD_HIGH, {8'h00, v[23:16]}, 2'b11, RESP_OKAY);
        // Software spacing before the next reprogramming
        repeat (REPROG_GAP_CYCLES) @(posedge clk);
    endtask : set_period

    // One full slow-clock cycle, about 610 fast cycles
    task automatic slow_tick();
        @(posedge clk);
        rtc_clk_in <= 1'b1;
        repeat (305) @(posedge clk);
        rtc_clk_in <= 1'b0;
        repeat (305) @(posedge clk);
    endtask : slow_tick

    task automatic chk_flag(input logic v);
        checks++;
        if (long_timer_irq_flag !== v) begin
            num_errors++;
            $display("mismatch %0t interrupt flag", $time);
        end
    endtask : chk_flag

    // ****************************************************************
    // Response watcher
    // ****************************************************************
    always @(posedge clk) begin
        if (rsp.bvalid === 1'b1 && req.bready === 1'b1) begin
            checks++;
            if (exp_b.size() == 0 || rsp.bresp !== exp_b[0]) begin
                num_errors++;
                $display("mismatch %0t write response", $time);
            end
            if (exp_b.size() != 0) void'(exp_b.pop_front());
        end
        if (rsp.rvalid === 1'b1 && req.rready === 1'b1) begin
            checks++;
            if (exp_rd.size() == 0 || rsp.rdata !== {16'h0000, exp_rd[0]} || rsp.rresp !== exp_rr[0]) begin
                num_errors++;
                $display("mismatch %0t read data %h", $time, rsp.rdata);
            end
            if (exp_rd.size() != 0) begin
                void'(exp_rd.pop_front());
                void'(exp_rr.pop_front());
            end
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        arst_n     = 1'b0;
        ce         = 1'b1;
        warm_reset = 1'b0;
        rtc_clk_in = 1'b0;
        req        = '0;
        num_errors = 0;
        checks     = 0;
        seed       = 32'h894e52ce;
        zero_regs  = '{IDX_PERIOD_LOW, IDX_PERIOD_HIGH, IDX_COUNT_LOW, IDX_COUNT_HIGH,
                       IDX_CYCLE_LOW, IDX_CYCLE_HIGH, IDX_IRQ_STATUS};
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        for (k = 0; k < 7; k++) rd(zero_regs[k], 16'h0000, RESP_OKAY);
        rd(32'h0b0000e0, 16'h0000, RESP_SLVERR);
        wr(32'h0b0000e0, 16'h00ff, 2'b11, RESP_SLVERR);
        // Low half alone must not start the counter
        wr(IDX_PERIOD_LOW, 16'h0006, 2'b11, RESP_OKAY);
        slow_tick();
        cnt(24'h000000);
        wr(IDX_PERIOD_HIGH, 16'h0000, 2'b11, RESP_OKAY);
        repeat (REPROG_GAP_CYCLES) @(posedge clk);
        cnt(24'h000006);
        rd(IDX_PERIOD_LOW, 16'h0006, RESP_OKAY);
        for (k = 1; k <= 6; k++) begin
            slow_tick();
            cnt((k < 6) ? 24'(6 - k) : 24'h000006);
            chk_flag(k == 6);
        end
        cnt(24'h000006);
        rd(IDX_IRQ_STATUS, 16'h0004, RESP_OKAY);
        wr(IDX_IRQ_STATUS, 16'h0000, 2'b11, RESP_OKAY);
        chk_flag(1'b1);
        wr(IDX_IRQ_STATUS, 16'h0004, 2'b11, RESP_OKAY);
        chk_flag(1'b0);
        cur = 24'h000006;
        for (k = 0; k < 3; k++) begin
            p = 24'($random(seed));
            if (p[23:16] == 8'h00 && p[15:0] <= 16'h0004) p[16] = 1'b1;
            wr(IDX_PERIOD_HIGH, {8'h00, p[23:16]}, 2'b11, RESP_OKAY);
            cnt(cur);
            wr(IDX_PERIOD_LOW, p[15:0], 2'b11, RESP_OKAY);
            repeat (REPROG_GAP_CYCLES) @(posedge clk);
            cnt(p);
            cur = p;
        end
        wr(IDX_CYCLE_LOW, 16'hbeef, 2'b11, RESP_OKAY);
        wr(IDX_CYCLE_HIGH, 16'h01a5, 2'b11, RESP_OKAY);
        rd(IDX_CYCLE_LOW, 16'hbeef, RESP_OKAY);
        rd(IDX_CYCLE_HIGH, 16'h01a5, RESP_OKAY);
        @(posedge clk);
        warm_reset <= 1'b1;
        repeat (2) @(posedge clk);
        warm_reset <= 1'b0;
        rd(IDX_CYCLE_LOW, 16'h0000, RESP_OKAY);
        rd(IDX_CYCLE_HIGH, 16'h0000, RESP_OKAY);
        rd(IDX_PERIOD_LOW, cur[15:0], RESP_OKAY);
        rd(IDX_PERIOD_HIGH, {8'h00, cur[23:16]}, RESP_OKAY);
        slow_tick();
        cnt(cur - 24'h000001);
        wr(IDX_COUNT_LOW, 16'h1234, 2'b11, RESP_OKAY);
        cnt(cur - 24'h000001);
        // A whole slow cycle with the enable low must not count
        ce <= 1'b0;
        slow_tick();
        ce <= 1'b1;
        cnt(cur - 24'h000001);
        wr(IDX_CYCLE_LOW, 16'hffff, 2'b11, RESP_OKAY);
        wr(IDX_CYCLE_LOW, 16'h1200, 2'b10, RESP_OKAY);
        wr(IDX_CYCLE_LOW, 16'h0000, 2'b00, RESP_OKAY);
        rd(IDX_CYCLE_LOW, 16'h12ff, RESP_OKAY);
        set_period(24'h000000);
        cnt(24'h000000);
        repeat (2) slow_tick();
        cnt(24'h000000);
        chk_flag(1'b0);
        // Clear write timed to meet the reload tick in the same cycle
        set_period(24'h000005);
        repeat (4) slow_tick();
        cnt(24'h000001);
        rtc_clk_in <= 1'b1;
        wr(IDX_IRQ_STATUS, 16'h0004, 2'b11, RESP_OKAY);
        chk_flag(1'b1);
        cnt(24'h000005);
        rtc_clk_in <= 1'b0;
        // Clock-unit reset in mid-run clears everything
        set_period(24'h000010);
        wr(IDX_CYCLE_LOW, 16'h0055, 2'b11, RESP_OKAY);
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        for (k = 0; k < 7; k++) rd(zero_regs[k], 16'h0000, RESP_OKAY);
        chk_flag(1'b0);
        repeat (5) @(posedge clk);
        wrap_up();
    end

endmodule : long_period_countdown_timer_bench
